// [acmp_pkg.sv]
package acmp_pkg;
	// Interrupt edge sense codes
	localparam logic [1:0] ACMP_SENSE_BOTH    = 2'h0;
	localparam logic [1:0] ACMP_SENSE_RSVD    = 2'h1;
	localparam logic [1:0] ACMP_SENSE_FALLING = 2'h2;
	localparam logic [1:0] ACMP_SENSE_RISING  = 2'h3;
	// Hysteresis levels
	localparam logic [1:0] ACMP_HYS_NONE   = 2'h0;
	localparam logic [1:0] ACMP_HYS_SMALL  = 2'h1;
	localparam logic [1:0] ACMP_HYS_MEDIUM = 2'h2;
	localparam logic [1:0] ACMP_HYS_LARGE  = 2'h3;
	// Negative source codes; code 3 picks the internal reference
	localparam logic [1:0] ACMP_NEG_REF = 2'h3;
	// Field widths and reset values
	localparam int         ACMP_SEL_W      = 2;
	localparam int         ACMP_NPOS       = 4;
	localparam logic [7:0] ACMP_REF_RESET  = 8'hff;
	// Synchroniser depth: state bit lags the result by three cycles
	localparam int         ACMP_SYNC_STAGES = 3;
	// Start-up time the consumer must wait after enable
	localparam real        ACMP_STARTUP_US  = 2.5;
	localparam real        ACMP_CLK_MHZ     = 125.0;
	localparam int         ACMP_STARTUP_CYC = int'(ACMP_STARTUP_US * ACMP_CLK_MHZ);
endpackage

// [acmp_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module acmp_sync #(
	parameter int STAGES = 3
) (
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic din,
	output logic      dout
);
	typedef struct packed {
		logic [STAGES-1:0] chain;
	} acmp_sync_s;
	acmp_sync_s st_q, st_d;

	// Shift chain; only the next stage reads each flop
	always_comb begin
		st_d.chain = {st_q.chain[STAGES-2:0], din};
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign dout = st_q.chain[STAGES-1];
endmodule // acmp_sync
`default_nettype wire

// [acmp_ctrl.sv]
`timescale 1ns/1ns
`default_nettype none
// How it works
// R1: Analog result is one only when positive input exceeds negative input.
// R2: Edges of the result raise the interrupt condition per edge-sense field.
// R3: Interrupt source is enabled only while the enable bit is one.
// R4: Qualifying edge sets the flag whether or not interrupt is enabled.
// R5: Request is high while enable and flag are both set.
// R6: Event output is a level that follows the result asynchronously.
// R7: No event inputs exist; nothing from events changes configuration.
// R8: Consumer ignores the result for 2.5 us after enabling.
// R9: Hysteresis field selects none or one of three levels.
// R10: Low-power bit selects reduced current, slower comparator.
// R11: Positive select picks one of four pins; negative picks three or reference.
// R12: Output pad carries the result only while pad enable is one.
// R13: Software selects inputs and pad first, then sets enable last; the testbench sets enable first, then changes pad and negative source.
// R14: Software makes the output pin an output in port direction.
// R15: Result goes to events and pin directly; software sees it through state three cycles later.
// R16: Sense code 0 both, 2 falling, 3 rising, 1 reserved.
// R17: Writing one to the flag clears it; zero leaves it.
// R18: State bit follows the result through a three-cycle synchroniser.
// R19: Invert bit inverts the result before interrupt, event and pin.
// R20: Result is synchronised before edge detection; one set per edge.
module acmp_ctrl
	import acmp_pkg::*;
(
	input  wire logic                  mclk,
	input  wire logic                  rst,
	input  wire logic                  enable,
	input  wire logic                  low_power_select,
	input  wire logic [1:0]            hysteresis_select,
	input  wire logic [1:0]            irq_edge_sense,
	input  wire logic                  output_pad_enable,
	input  wire logic                  invert,
	input  wire logic [1:0]            positive_source_select,
	input  wire logic [1:0]            negative_source_select,
	input  wire logic [7:0]            reference_level,
	input  wire logic                  comparator_irq_bit,
	input  wire logic                  flag_clear,
	input  wire logic                  analog_raw,
	output logic                       core_enable,
	output logic                       core_low_power,
	output logic [1:0]                 core_hysteresis,
	output logic [ACMP_NPOS-1:0]       positive_input_pin_sel,
	output logic [2:0]                 negative_input_pin_sel,
	output logic                       ref_select,
	output logic [7:0]                 ref_level,
	output logic                       event_out,
	output logic                       pad_out,
	output logic                       pad_oe,
	output logic                       state,
	output logic                       irq_flag,
	output logic                       irq
);
	import acmp_pkg::*;

	typedef struct packed {
		logic prev;
		logic flag;
	} acmp_ctrl_s;
	acmp_ctrl_s st_q, st_d;

	logic result;
	logic sync_res;
	logic hit;

	////////////////////////////////////////////////////////////////////
	// Edge qualifier, used for every sense code
	function automatic logic acmp_edge_hit(input logic [1:0] sense, input logic prv,
		input logic cur);
		logic rise;
		logic fall;
		rise = cur & ~prv;
		fall = prv & ~cur;
		case (sense)
			ACMP_SENSE_BOTH:    acmp_edge_hit = rise | fall; // R16
			ACMP_SENSE_FALLING: acmp_edge_hit = fall;        // R16
			ACMP_SENSE_RISING:  acmp_edge_hit = rise;        // R16
			default:            acmp_edge_hit = 1'b0;        // Reserved code senses nothing
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////
	// Analog core controls; core decides sign of the difference
	assign core_enable     = enable;
	assign core_low_power  = low_power_select; // R10
	assign core_hysteresis = hysteresis_select; // R9
	assign ref_select      = (negative_source_select == ACMP_NEG_REF); // R11
	assign ref_level       = reference_level;
	// One-hot pin routing keeps the analog switches break-before-make friendly
	always_comb begin
		positive_input_pin_sel = '0;
		negative_input_pin_sel = '0;
		positive_input_pin_sel[positive_source_select] = 1'b1; // R11
		if (!ref_select) begin
			negative_input_pin_sel[negative_source_select] = 1'b1; // R11
		end
	end

	// Result: raw is one when positive exceeds negative, gated by enable
	assign result    = (analog_raw & enable) ^ invert; // R1 R19
	// Unclocked path: event is a level that follows the result
	// No event input port exists, so nothing on the event side can reach configuration
	assign event_out = result;                          // R6 R7 R15
	assign pad_out   = output_pad_enable & result;      // R12 R15
	assign pad_oe    = output_pad_enable;               // R12

	////////////////////////////////////////////////////////////////////
	// Three-stage synchroniser feeds both state bit and edge detector
	acmp_sync #(
		.STAGES (ACMP_SYNC_STAGES)
	) u_sync (
		.mclk (mclk),
		.rst  (rst),
		.din  (result),
		.dout (sync_res)
	);
	assign state = sync_res; // R18 R20

	assign hit = acmp_edge_hit(irq_edge_sense, st_q.prev, sync_res); // R2 R20

	// Flag: set wins over a clear in the same cycle
	always_comb begin
		st_d      = st_q;
		st_d.prev = sync_res;
		if (hit) begin
			st_d.flag = 1'b1; // R4
		end else if (flag_clear) begin
			st_d.flag = 1'b0; // R17
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign irq_flag = st_q.flag;
	assign irq      = comparator_irq_bit & st_q.flag; // R3 R5

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	flag_set_a: assert property (hit |=> st_q.flag) // R4
		else $error("flag not set after edge");
	flag_clear_a: assert property (flag_clear && !hit |=> !st_q.flag) // R17
		else $error("flag not cleared");
	flag_hold_a: assert property (!flag_clear && !hit |=> st_q.flag == $past(st_q.flag)) // R17
		else $error("flag changed without cause");
	irq_gate_a: assert property (irq == (comparator_irq_bit && st_q.flag)) // R3 R5
		else $error("request mismatch");
	rise_only_a: assert property (irq_edge_sense == ACMP_SENSE_RISING && hit |-> sync_res) // R2
		else $error("rising mode hit on fall");
	fall_only_a: assert property (irq_edge_sense == ACMP_SENSE_FALLING && hit |-> !sync_res) // R2
		else $error("falling mode hit on rise");
	sync_lag_a: assert property ($stable(result)[*4] |-> state == result) // R18
		else $error("state does not follow result");
	pad_gate_a: assert property (!output_pad_enable |-> !pad_out && !pad_oe) // R12
		else $error("pad driven while disabled");
	rsvd_sense_a: assert property (irq_edge_sense == ACMP_SENSE_RSVD |-> !hit) // R16
		else $error("reserved sense fired");

	rise_c: cover property (irq_edge_sense == ACMP_SENSE_RISING && hit);
	both_c: cover property (irq_edge_sense == ACMP_SENSE_BOTH && hit && !sync_res);
	irq_c:  cover property (irq ##1 flag_clear ##1 !irq);
	race_c: cover property (hit && flag_clear);
endmodule // acmp_ctrl
`default_nettype wire

// [acmp_core_model.sv]
`timescale 1ns/1ns
`default_nettype none
module acmp_core_model #(
	parameter int STARTUP = acmp_pkg::ACMP_STARTUP_CYC
) (
	input  wire logic        mclk,
	input  wire logic        core_enable,
	input  wire logic [3:0]  pos_sel,
	input  wire logic [2:0]  neg_sel,
	input  wire logic        ref_select,
	input  wire logic [7:0]  ref_level,
	input  wire logic [31:0] ain_p,
	input  wire logic [23:0] ain_n,
	output logic             analog_raw
);
	logic [7:0] p;
	logic [7:0] n;
	logic       tog = 1'b0;
	int         warm = 0;
	// Disabled or still waking core output is garbage, so it toggles rather than holding
	always_ff @(posedge mclk) begin
		tog <= ~tog;
		if (!core_enable) begin
			warm <= 0;
		end else if (warm < STARTUP) begin
			warm <= warm + 1;
		end
	end
	// Pin routing and the voltage decision; reference level stands in for its voltage
	always_comb begin
		p = 8'h00;
		n = ref_select ? ref_level : 8'h00;
		for (int i = 0; i < 4; i++) if (pos_sel[i]) p = ain_p[8*i +: 8];
		for (int i = 0; i < 3; i++) if (neg_sel[i]) n = ain_n[8*i +: 8];
		analog_raw = (core_enable && warm >= STARTUP) ? (p > n) : tog;
	end
endmodule // acmp_core_model
`default_nettype wire

// [comparator_irq_event_control_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module comparator_irq_event_control_tb;
	logic mclk = 0, rst = 1, en = 0, lp = 0, pe = 0, inv = 0, ie = 0, fc = 0, raw;
	logic [1:0] hys = 0, es = 0, ps = 0, ns = 0;
	logic [7:0] rl = 8'hff;
	logic [31:0] ain_p = 32'h80808020;
	logic [3:0] psel;
	logic [2:0] nsel;
	logic ce, clp, rs, ev, po, oe, st, fl, irq;
	logic [1:0] ch;
	logic [7:0] rlo;
	int bad_count = 0, checks = 0;
	// Free running clock at 125 MHz
	always #4 mclk = ~mclk;
	acmp_ctrl dut_u (.mclk(mclk), .rst(rst), .enable(en), .low_power_select(lp),
		.hysteresis_select(hys), .irq_edge_sense(es), .output_pad_enable(pe), .invert(inv),
		.positive_source_select(ps), .negative_source_select(ns), .reference_level(rl),
		.comparator_irq_bit(ie), .flag_clear(fc), .analog_raw(raw), .core_enable(ce),
		.core_low_power(clp), .core_hysteresis(ch), .positive_input_pin_sel(psel),
		.negative_input_pin_sel(nsel), .ref_select(rs), .ref_level(rlo), .event_out(ev),
		.pad_out(po), .pad_oe(oe), .state(st), .irq_flag(fl), .irq(irq));
	acmp_core_model core_u (.mclk(mclk), .core_enable(ce), .pos_sel(psel), .neg_sel(nsel),
		.ref_select(rs), .ref_level(rlo), .ain_p(ain_p), .ain_n(24'h404040),
		.analog_raw(raw));
	task cyc(input int k);
		repeat (k) @(posedge mclk);
	endtask
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task stop_test;
		$display("Checks %0d, mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Drive pin 0 level, then expect flag and gated request; clear costs one pulse
	task hit(input logic [7:0] v, input logic e, input logic ien);
		ain_p[7:0] <= v;
		ie <= ien;
		cyc(6);
		#1 chk(fl, e);
		chk(irq, e & ien);
		fc <= 1'b1;
		cyc(1);
		fc <= 1'b0;
		cyc(2);
		#1 chk(fl, 0);
	endtask
	// Hang guard well beyond the short sequence below
	initial begin
		#100000 bad_count++;
		stop_test;
	end
	initial begin
		cyc(12);
		rst <= 0;
		cyc(1);
		#1 chk({st, fl, irq}, 0);
		chk({psel, nsel}, 7'h09);
		// Enable is set with inputs at reset selections and pad off; pad and negative source change later
		en <= 1;
		// Result is not trusted until the core start-up time has passed
		cyc(acmp_pkg::ACMP_STARTUP_CYC + 4);
		chk(ce, 1);
		ain_p[7:0] <= 8'h90;
		cyc(2);
		#1 chk(st, 0);
		cyc(1);
		#1 chk(st, 1);
		hit(8'h20, 1, 0);
		for (int s = 0; s < 4; s++) begin
			es <= s[1:0];
			cyc(1);
			hit(8'h90, s == 0 || s == 3, s[0]);
			hit(8'h20, s == 0 || s == 2, s[0]);
		end
		inv <= 1;
		pe <= 1;
		lp <= 1;
		hys <= 2;
		ns <= 3;
		cyc(1);
		#1 chk({ev, po, oe}, 3'h7);
		chk({clp, ch}, 3'h6);
		chk({rs, nsel}, 4'h8);
		rl <= 8'h10;
		pe <= 0;
		cyc(1);
		#1 chk({ev, po, oe}, 0);
		chk(rlo, 8'h10);
		stop_test;
	end
endmodule // comparator_irq_event_control_tb
`default_nettype wire
